// ### hw/lsu_cfg.svh
// Constants of the least-squares update datapath: offsets, fields, limits.
// Assumes inclusion by the datapath top and the multiply-accumulate unit files only.
//
// Notes on behaviour
// RQ1 - Basic update runs a multiply-accumulate and a shifted add in one cycle.
// RQ2 - Basic multiplier takes both memory operands sign-extended to 17 bits.
// RQ3 - Fractional mode doubles the product; multiply saturation follows its mode bit.
// RQ4 - Product sign-extends to 40 bits, adds to destination; wide mode picks overflow.
// RQ5 - Accumulation overflow sets destination flag and saturates when enabled.
// RQ6 - Basic add: first operand shifted 16, extended per sign mode, plus source.
// RQ7 - Basic add overflow and carry both follow wide overflow mode.
// RQ8 - Basic add is rounded; only the rounded value is checked and saturated.
// RQ9 - Legacy mode keeps low 16 bits and skips overflow handling on the add.
// RQ10 - Filter form: temp product, product accumulation, rounded add to memory.
// RQ11 - First multiplier: temp times second operand, 17-bit inputs, flagged, saturated.
// RQ12 - Second multiplier: both operands, product added to destination, flagged.
// RQ13 - Filter add: shifted first operand plus accumulator, overflow handled after shift.
// RQ14 - Filter add acts as wide mode cleared: overflow and carry at bit 31.
// RQ15 - Filter add always rounded; rounding mode zero adds 2^15.
// RQ16 - Rounding mode one adds 2^15 above half, or at half when bit 16 set.
// RQ17 - Filter form writes upper half of rounded sum to first operand location.
// RQ18 - Halt stalls until interrupt or reset; mask and power mode register matter.
// RQ19 - Halt under repeat is rejected; both update forms may repeat.
// RQ20 - Linear qualifier only pairs with indirect-addressing update instructions.
// RQ21 - Qualified update moves the pointer linearly, ignoring circular length.
`ifndef LSU_CFG_SVH
`define LSU_CFG_SVH

// =====================================================
// Register offsets
`define LSU_OFF_MODE   8'h00
`define LSU_OFF_CMD    8'h04
`define LSU_OFF_OPND   8'h08
`define LSU_OFF_TEMP   8'h0c
`define LSU_OFF_STAT   8'h10
`define LSU_OFF_WBACK  8'h14
`define LSU_OFF_PTR    8'h18
`define LSU_ACC_BASE   3'h1
`define LSU_MODE_RST   32'h0000_0000
`define LSU_PTR_RST    32'h0000_0000

// =====================================================
// Mode register bits
`define LSU_B_FRAC     0
`define LSU_B_MULSAT   1
`define LSU_B_WIDE     2
`define LSU_B_SATEN    3
`define LSU_B_SIGNX    4
`define LSU_B_RNDSEL   5
`define LSU_B_LEGACY   6
`define LSU_B_INTMASK  7
`define LSU_F_PWR      10:8

// =====================================================
// Command and status fields
`define LSU_F_OP       1:0
`define LSU_F_SRC      3:2
`define LSU_F_DST      5:4
`define LSU_B_LINEAR   6
`define LSU_B_REPEAT   7
`define LSU_B_HALTED   0
`define LSU_B_CARRY    1
`define LSU_F_OVF      5:2
`define LSU_B_REJECT   6
`define LSU_B_INTTAKEN 7

// =====================================================
// Arithmetic limits
`define LSU_HALF       16'h8000
`define LSU_RND_ADD    41'h000_0000_8000
`define LSU_MUL_MAX    32'h7fff_ffff
`define LSU_POS40      40'h7f_ffff_ffff
`define LSU_NEG40      40'h80_0000_0000
`define LSU_POS32      40'h00_7fff_ffff
`define LSU_NEG32      40'hff_8000_0000
`define LSU_RESP_OK    2'b00
`define LSU_RESP_ERR   2'b10

`endif

// ### hw/lsu_datapath.sv
// Least-squares update datapath top with AXI4-Lite register slave.
// Assumes one clock, an asynchronous active-low reset, and an
// interrupt request pin from another domain.
`include "lsu_cfg.svh"

module lsu_datapath (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic      [1:0]  s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	// Wake request pin
	input  wire logic        irq_req,
	// Core side
	output logic             exec_stall,
	output logic      [2:0]  power_mode,
	output logic             mem_wr_en,
	output logic      [15:0] mem_wr_data
);
	// =====================================================
	// Bus slave state
	logic        aw_got;
	logic        w_got;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic [31:0] wmask;

	assign do_write = aw_got & w_got & ~s_axi_bvalid;
	assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

	// =====================================================
	// Registers
	logic [31:0] mode;
	logic [31:0] opnd;
	logic [15:0] temp;
	logic [15:0] ptr;
	logic [7:0]  circ_len;
	logic [15:0] wback;
	logic        carry;
	logic        reject;
	logic        int_taken;
	logic [3:0]  ovf_flag;
	logic [39:0] acc [0:3];
	lsu_pkg::lsu_state_t state;
	lsu_pkg::lsu_state_t next_state;

	// =====================================================
	// Write decode
	logic       wr_mode;
	logic       wr_cmd;
	logic       wr_opnd;
	logic       wr_temp;
	logic       wr_stat;
	logic       wr_ptr;
	logic       wr_acc;
	logic       wr_ok;
	logic [1:0] wr_acc_sel;
	logic       wr_acc_hi;

	assign wr_mode = do_write & (aw_addr == `LSU_OFF_MODE);
	assign wr_cmd = do_write & (aw_addr == `LSU_OFF_CMD);
	assign wr_opnd = do_write & (aw_addr == `LSU_OFF_OPND);
	assign wr_temp = do_write & (aw_addr == `LSU_OFF_TEMP);
	assign wr_stat = do_write & (aw_addr == `LSU_OFF_STAT);
	assign wr_ptr = do_write & (aw_addr == `LSU_OFF_PTR);
	assign wr_acc = do_write & (aw_addr[7:5] == `LSU_ACC_BASE) & (aw_addr[1:0] == 2'b00);
	assign wr_acc_sel = aw_addr[4:3];
	assign wr_acc_hi = aw_addr[2];
	assign wr_ok = wr_mode | wr_cmd | wr_opnd | wr_temp | wr_stat | wr_ptr | wr_acc
		| (aw_addr == `LSU_OFF_WBACK);

	// =====================================================
	// Command decode
	lsu_pkg::lsu_op_t cmd_op;
	logic [1:0] src;
	logic [1:0] dst;
	logic       linear;
	logic       start;
	logic       op_update;
	logic       op_filter;
	logic       op_halt;
	logic       halt_bad;
	logic       halt_ok;
	logic       exec;

	assign cmd_op = lsu_pkg::lsu_op_t'(w_data[`LSU_F_OP]);
	assign src = w_data[`LSU_F_SRC];
	assign dst = w_data[`LSU_F_DST];
	assign linear = w_data[`LSU_B_LINEAR];
	assign start = wr_cmd & (state == lsu_pkg::LSU_ST_RUN);
	assign op_update = start & (cmd_op == lsu_pkg::LSU_OP_UPDATE);
	assign op_filter = start & (cmd_op == lsu_pkg::LSU_OP_FILTER);
	assign op_halt = start & (cmd_op == lsu_pkg::LSU_OP_HALT);
	assign halt_bad = op_halt & (w_data[`LSU_B_REPEAT] | linear); // [RQ19] [RQ20]
	assign halt_ok = op_halt & ~halt_bad; // [RQ18]
	assign exec = op_update | op_filter; // [RQ1] [RQ10]

	// =====================================================
	// Operands and modes
	logic [15:0] op_x;
	logic [15:0] op_y;
	logic [39:0] src_acc;
	logic [39:0] dst_acc;
	logic        legacy;
	logic        sat_en;

	assign op_x = opnd[15:0];
	assign op_y = opnd[31:16];
	assign src_acc = acc[src];
	assign dst_acc = acc[dst];
	assign legacy = mode[`LSU_B_LEGACY];
	assign sat_en = mode[`LSU_B_SATEN];

	// =====================================================
	// Multiplier units
	logic [39:0] pair_res;
	logic        pair_ovf;
	logic [39:0] temp_res;
	logic        temp_ovf;

	lsu_mac_unit u_mac_pair (
		.op_a                     (op_x),
		.op_b                     (op_y),
		.acc_in                   (dst_acc),
		.fractional_mode          (mode[`LSU_B_FRAC]),
		.multiply_saturation_mode (mode[`LSU_B_MULSAT]),
		.wide_overflow_mode       (mode[`LSU_B_WIDE]),
		.saturation_enable        (sat_en),
		.acc_out                  (pair_res),
		.overflow                 (pair_ovf)
	); // [RQ1] [RQ2] [RQ12]

	lsu_mac_unit u_mac_temp (
		.op_a                     (temp),
		.op_b                     (op_y),
		.acc_in                   (40'h00_0000_0000),
		.fractional_mode          (mode[`LSU_B_FRAC]),
		.multiply_saturation_mode (mode[`LSU_B_MULSAT]),
		.wide_overflow_mode       (mode[`LSU_B_WIDE]),
		.saturation_enable        (sat_en),
		.acc_out                  (temp_res),
		.overflow                 (temp_ovf)
	); // [RQ11]

	// =====================================================
	// Shifted add, rounding, saturation
	logic [39:0] shx;
	logic [40:0] alu_sum;
	logic [40:0] usum40;
	logic [32:0] usum32;
	logic        eff_wide;
	logic        alu_carry;
	logic        rnd_up;
	logic [40:0] rnd_sum;
	logic        alu_ovf;
	logic        alu_ovf_rep;
	logic [39:0] alu_sat;
	logic [39:0] alu_val;
	logic [39:0] alu_res;

	assign shx = {(mode[`LSU_B_SIGNX] ? {8{op_x[15]}} : 8'h00), op_x, 16'h0000}; // [RQ6] [RQ13]
	assign alu_sum = {src_acc[39], src_acc} + {shx[39], shx}; // [RQ6]
	assign usum40 = {1'b0, src_acc} + {1'b0, shx};
	assign usum32 = {1'b0, src_acc[31:0]} + {1'b0, shx[31:0]};
	assign eff_wide = op_update & mode[`LSU_B_WIDE]; // [RQ7] [RQ14]
	assign alu_carry = eff_wide ? usum40[40] : usum32[32]; // [RQ7] [RQ14]
	assign rnd_up = ~mode[`LSU_B_RNDSEL] | (alu_sum[15:0] > `LSU_HALF) // [RQ15] [RQ16]
		| ((alu_sum[15:0] == `LSU_HALF) & alu_sum[16]);
	assign rnd_sum = alu_sum + (rnd_up ? `LSU_RND_ADD : 41'h000_0000_0000); // [RQ8] [RQ15]
	assign alu_ovf = eff_wide ? (rnd_sum[40] ^ rnd_sum[39]) // [RQ8] [RQ14]
		: (rnd_sum[40:31] != {10{rnd_sum[40]}});
	assign alu_ovf_rep = alu_ovf & (op_filter | ~legacy); // [RQ9] [RQ13]
	assign alu_sat = eff_wide ? (rnd_sum[40] ? `LSU_NEG40 : `LSU_POS40)
		: (rnd_sum[40] ? `LSU_NEG32 : `LSU_POS32);
	assign alu_res = legacy ? rnd_sum[39:0] : {rnd_sum[39:16], 16'h0000}; // [RQ9]
	assign alu_val = (alu_ovf_rep & sat_en) ? alu_sat : alu_res; // [RQ8] [RQ13]

	// =====================================================
	// Accumulators and overflow flags
	logic [39:0] next_acc [0:3];
	logic [3:0]  next_ovf;

	generate
		for (genvar i = 0; i < 4; i++) begin : g_acc
			logic hit_dst;
			logic hit_src;
			logic set_ovf;

			assign hit_dst = exec & (dst == 2'(i));
			assign hit_src = exec & (src == 2'(i));
			assign next_acc[i] = hit_dst ? pair_res // [RQ4] [RQ12]
				: hit_src ? (op_filter ? temp_res : alu_val) // [RQ6] [RQ11]
				: (wr_acc & (wr_acc_sel == 2'(i)) & wr_acc_hi)
					? {w_data[7:0], acc[i][31:0]}
				: (wr_acc & (wr_acc_sel == 2'(i))) ? {acc[i][39:32], w_data}
				: acc[i];
			assign set_ovf = (hit_dst & pair_ovf) // [RQ5] [RQ12]
				| (hit_src & (op_filter ? (temp_ovf | alu_ovf_rep) : alu_ovf_rep));
			assign next_ovf[i] = set_ovf
				| (ovf_flag[i] & ~(wr_stat & w_data[2 + i] & w_strb[0]));

			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					acc[i] <= 40'h00_0000_0000;
					ovf_flag[i] <= 1'b0;
				end else begin
					acc[i] <= next_acc[i];
					ovf_flag[i] <= next_ovf[i];
				end
			end
		end
	endgenerate

	// =====================================================
	// Wake pin synchroniser, change taken when stages agree
	logic irq_s1;
	logic irq_s2;
	logic irq_s3;
	logic irq_lvl;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irq_s1 <= 1'b0;
			irq_s2 <= 1'b0;
			irq_s3 <= 1'b0;
			irq_lvl <= 1'b0;
		end else begin
			irq_s1 <= irq_req;
			irq_s2 <= irq_s1;
			irq_s3 <= irq_s2;
			if (irq_s2 == irq_s3) begin
				irq_lvl <= irq_s3;
			end
		end
	end

	// =====================================================
	// Halt sequencer
	logic wake;

	assign wake = (state == lsu_pkg::LSU_ST_HALT) & irq_lvl; // [RQ18]

	always_comb begin
		case (state)
			lsu_pkg::LSU_ST_RUN:  next_state = halt_ok ? lsu_pkg::LSU_ST_HALT : state;
			lsu_pkg::LSU_ST_HALT: next_state = wake ? lsu_pkg::LSU_ST_RUN : state;
			default:              next_state = lsu_pkg::LSU_ST_RUN;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= lsu_pkg::LSU_ST_RUN;
			exec_stall <= 1'b0;
			power_mode <= 3'h0;
		end else begin
			state <= next_state;
			exec_stall <= (next_state == lsu_pkg::LSU_ST_HALT); // [RQ18]
			power_mode <= (next_state == lsu_pkg::LSU_ST_HALT) ? mode[`LSU_F_PWR] : 3'h0;
		end
	end

	// =====================================================
	// Pointer post-update
	logic [15:0] ptr_inc;
	logic        ptr_wrap;

	assign ptr_inc = ptr + 16'h0001;
	assign ptr_wrap = (circ_len != 8'h00) & ~linear & (ptr_inc >= {8'h00, circ_len}); // [RQ21]

	// =====================================================
	// Control and status registers
	logic stat_clr0;

	assign stat_clr0 = wr_stat & w_strb[0];

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mode <= `LSU_MODE_RST;
			opnd <= 32'h0000_0000;
			temp <= 16'h0000;
			{circ_len, ptr} <= 24'h00_0000;
		end else begin
			if (wr_mode) mode <= (mode & ~wmask) | (w_data & wmask);
			if (wr_opnd) opnd <= (opnd & ~wmask) | (w_data & wmask);
			if (wr_temp) temp <= w_data[15:0];
			if (exec) ptr <= ptr_wrap ? 16'h0000 : ptr_inc; // [RQ21]
			else if (wr_ptr) {circ_len, ptr} <= w_data[23:0];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			carry <= 1'b0;
			reject <= 1'b0;
			int_taken <= 1'b0;
			wback <= 16'h0000;
			mem_wr_en <= 1'b0;
			mem_wr_data <= 16'h0000;
		end else begin
			if (exec) carry <= alu_carry; // [RQ7] [RQ14]
			reject <= halt_bad | (reject & ~(stat_clr0 & w_data[`LSU_B_REJECT])); // [RQ19]
			int_taken <= (wake & ~mode[`LSU_B_INTMASK]) // [RQ18]
				| (int_taken & ~(stat_clr0 & w_data[`LSU_B_INTTAKEN]));
			if (op_filter) wback <= alu_val[31:16]; // [RQ17]
			mem_wr_en <= op_filter; // [RQ17]
			mem_wr_data <= op_filter ? alu_val[31:16] : mem_wr_data; // [RQ17]
		end
	end

	// =====================================================
	// Read decode
	logic [1:0]  rd_sel;
	logic        rd_acc;
	logic [39:0] rd_accv;
	logic [31:0] rd_stat;
	logic [31:0] rd_val;
	logic        rd_ok;

	assign rd_sel = s_axi_araddr[4:3];
	assign rd_acc = (s_axi_araddr[7:5] == `LSU_ACC_BASE) & (s_axi_araddr[1:0] == 2'b00);
	assign rd_accv = acc[rd_sel];
	assign rd_stat = {24'h00_0000, int_taken, reject, ovf_flag, carry,
		state == lsu_pkg::LSU_ST_HALT};
	assign rd_val = (s_axi_araddr == `LSU_OFF_MODE) ? mode
		: (s_axi_araddr == `LSU_OFF_OPND) ? opnd
		: (s_axi_araddr == `LSU_OFF_TEMP) ? {16'h0000, temp}
		: (s_axi_araddr == `LSU_OFF_STAT) ? rd_stat
		: (s_axi_araddr == `LSU_OFF_WBACK) ? {16'h0000, wback}
		: (s_axi_araddr == `LSU_OFF_PTR) ? {8'h00, circ_len, ptr}
		: (rd_acc & s_axi_araddr[2]) ? {24'h00_0000, rd_accv[39:32]}
		: rd_acc ? rd_accv[31:0]
		: 32'h0000_0000;
	assign rd_ok = rd_acc | (s_axi_araddr == `LSU_OFF_MODE) | (s_axi_araddr == `LSU_OFF_CMD)
		| (s_axi_araddr == `LSU_OFF_OPND) | (s_axi_araddr == `LSU_OFF_TEMP)
		| (s_axi_araddr == `LSU_OFF_STAT) | (s_axi_araddr == `LSU_OFF_WBACK)
		| (s_axi_araddr == `LSU_OFF_PTR);

	// =====================================================
	// AXI4-Lite write channel
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LSU_RESP_OK;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `LSU_RESP_OK : `LSU_RESP_ERR;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// =====================================================
	// AXI4-Lite read channel
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `LSU_RESP_OK;
		end else begin
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_ok ? `LSU_RESP_OK : `LSU_RESP_ERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule : lsu_datapath

// ### hw/lsu_mac_unit.sv
// One multiply-accumulate unit: 17x17 multiply, accumulate, saturate.
// Assumes purely combinational use by the datapath top.
`include "lsu_cfg.svh"

module lsu_mac_unit (
	// Operands
	input  wire logic [15:0] op_a,
	input  wire logic [15:0] op_b,
	input  wire logic [39:0] acc_in,
	// Mode
	input  wire logic        fractional_mode,
	input  wire logic        multiply_saturation_mode,
	input  wire logic        wide_overflow_mode,
	input  wire logic        saturation_enable,
	// Result
	output logic      [39:0] acc_out,
	output logic             overflow
);
	logic signed [16:0] a17;
	logic signed [16:0] b17;
	logic signed [33:0] prod;
	logic        [31:0] prod_sh;
	logic        [31:0] prod_fin;
	logic        [40:0] sum;
	logic        [39:0] sat_val;
	logic               mul_sat;

	assign a17 = {op_a[15], op_a}; // [RQ2] [RQ11]
	assign b17 = {op_b[15], op_b}; // [RQ2] [RQ11]
	assign prod = a17 * b17;
	assign prod_sh = fractional_mode ? {prod[30:0], 1'b0} : prod[31:0]; // [RQ3]
	assign mul_sat = multiply_saturation_mode & fractional_mode
		& (op_a == `LSU_HALF) & (op_b == `LSU_HALF);
	assign prod_fin = mul_sat ? `LSU_MUL_MAX : prod_sh; // [RQ3]
	assign sum = {acc_in[39], acc_in} + {{9{prod_fin[31]}}, prod_fin}; // [RQ4]
	assign overflow = wide_overflow_mode ? (sum[40] ^ sum[39]) // [RQ4]
		: (sum[40:31] != {10{sum[40]}});
	assign sat_val = wide_overflow_mode ? (sum[40] ? `LSU_NEG40 : `LSU_POS40)
		: (sum[40] ? `LSU_NEG32 : `LSU_POS32);
	assign acc_out = (overflow & saturation_enable) ? sat_val : sum[39:0]; // [RQ5]
endmodule : lsu_mac_unit

// ### hw/lsu_pkg.sv
// Types shared by the least-squares update datapath.
// Assumes nothing of its surroundings.
package lsu_pkg;
	// =====================================================
	// Sequencer states
	typedef enum logic [1:0] {
		LSU_ST_RUN  = 2'b01,
		LSU_ST_HALT = 2'b10
	} lsu_state_t;

	// =====================================================
	// Command codes
	typedef enum logic [1:0] {
		LSU_OP_NONE   = 2'b00,
		LSU_OP_UPDATE = 2'b01,
		LSU_OP_FILTER = 2'b10,
		LSU_OP_HALT   = 2'b11
	} lsu_op_t;
endpackage : lsu_pkg

// ### tb/lsu_core_model.sv
// Core-side partner: takes write-back words, raises the wake request.
// Assumes the datapath's core pins and one clock.
module lsu_core_model (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// Bench control
	input  wire logic        wake,
	// Datapath side
	input  wire logic        exec_stall,
	input  wire logic        mem_wr_en,
	input  wire logic [15:0] mem_wr_data,
	output logic             irq_req,
	output logic      [15:0] mem_word
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================================
	// Memory word and wake line
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irq_req  <= 1'b0;
			mem_word <= 16'h0000;
		end else begin
			irq_req <= wake;
			if (mem_wr_en)
				mem_word <= mem_wr_data;
		end
	end
endmodule : lsu_core_model

// ### tb/lsu_datapath_assertions.sv
// Port checker for the datapath: command effects on the core pins.
// Assumes bind to the datapath top; commands arrive over AXI4-Lite.
module lsu_datapath_checker (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic        s_axi_bvalid,
	input  wire logic        irq_req,
	input  wire logic        exec_stall,
	input  wire logic [2:0]  power_mode,
	input  wire logic        mem_wr_en
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  ca;
	logic [31:0] cd;
	wire         cw = (ca == 8'h04);
	wire  [1:0]  op = cd[1:0];
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ca <= 8'h00;
			cd <= 32'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				ca <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
				cd <= s_axi_wdata;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// =====================================================
	// Assertions
	halt_entry_a: assert property ($rose(s_axi_bvalid) && cw && op == 2'h3 && !cd[7] && !cd[6]
		|-> exec_stall) else $error("halt not entered");
	halt_refuse_a: assert property ($rose(s_axi_bvalid) && cw && op == 2'h3 && (cd[7] || cd[6])
		|-> !$rose(exec_stall)) else $error("halt not refused");
	wb_pulse_a: assert property ($rose(s_axi_bvalid) && cw && op == 2'h2 && !$past(exec_stall)
		|-> mem_wr_en ##1 !mem_wr_en) else $error("write-back pulse wrong");
	wb_cause_a: assert property (mem_wr_en |-> $rose(s_axi_bvalid) && cw && op == 2'h2)
		else $error("write-back without filter command");
	basic_nowb_a: assert property ($rose(s_axi_bvalid) && cw && op == 2'h1 |-> !mem_wr_en)
		else $error("basic update wrote memory");
	pwr_idle_a: assert property (!exec_stall |-> power_mode == 3'h0)
		else $error("power mode while running");
	pwr_hold_a: assert property (exec_stall && $past(exec_stall) |-> $stable(power_mode))
		else $error("power mode moved while halted");
	wake_cause_a: assert property ($fell(exec_stall) |-> $past(irq_req, 2))
		else $error("woke without request");
	wake_bound_a: assert property ((exec_stall && irq_req) [*5] |=> !exec_stall)
		else $error("wake too slow");
endmodule : lsu_datapath_checker

bind lsu_datapath lsu_datapath_checker chk_u (.clk_sys, .reset_n, .s_axi_awvalid, .s_axi_awready,
	.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid, .irq_req,
	.exec_stall, .power_mode, .mem_wr_en);

// ### tb/lsu_datapath_tb.sv
// Testbench: register-level tests of both update forms and halt.
// Assumes the datapath, the core model and the bound checker.
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
	$display("wrong value %s exp %h seen %h", n, e, s); end end
module lsu_datapath_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, reset_n = 1'b0, wake = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire irq_req, exec_stall, mem_wr_en;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [2:0] power_mode;
	wire [15:0] mem_wr_data, mem_word;
	int errors = 0, n_checks = 0, cyc = 0;
	logic [1:0] rs;
	logic [31:0] rd;
	logic [39:0] av;
	logic [31:0] bm[4] = '{32'h00, 32'h40, 32'h08, 32'h0c};
	logic [39:0] b0[4] = '{40'h0011112222, 40'h0011112222, 40'h007fff0000, 40'h007fff0000};
	logic [39:0] be[4] = '{40'h0021110000, 40'h002111a222, 40'h007fffffff, 40'h008fff0000};
	logic [31:0] bs[4] = '{32'h0, 32'h0, 32'h4, 32'h0};
	logic [39:0] ra[4] = '{40'h8000, 40'h8000, 40'h18000, 40'hc000};
	logic [31:0] rm[4] = '{32'h00, 32'h20, 32'h20, 32'h20};
	logic [31:0] re[4] = '{32'h1, 32'h0, 32'h2, 32'h1};

	lsu_datapath dut_u (.clk_sys, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .irq_req, .exec_stall, .power_mode, .mem_wr_en, .mem_wr_data);
	lsu_core_model pm_u (.clk_sys, .reset_n, .wake, .exec_stall, .mem_wr_en, .mem_wr_data,
		.irq_req, .mem_word);

	always #5 clk_sys = ~clk_sys;

	// =====================================================
	// Bus tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid));
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	task automatic rdw(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask : rdw
	task automatic setacc(input int n, input logic [39:0] v);
		wr(8'(32 + 8 * n), v[31:0]);
		wr(8'(36 + 8 * n), {24'h0, v[39:32]});
	endtask : setacc
	task automatic getacc(input int n);
		rdw(8'(32 + 8 * n));
		av[31:0] = rd;
		rdw(8'(36 + 8 * n));
		av[39:32] = rd[7:0];
	endtask : getacc
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			conclude();
		end
	end

	// =====================================================
	// Tests
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rdw(8'h00); `CHK("mode reset", 32'h0, rd)
		rdw(8'h40); `CHK("unmapped rresp", 2'h2, rs)
		wr(8'h44, 32'h1); `CHK("unmapped bresp", 2'h2, rs)
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, bm[i]);
			setacc(0, b0[i]);
			setacc(1, 40'h0010000000);
			wr(8'h08, 32'h2000_1000);
			wr(8'h04, 32'h11);
			getacc(0); `CHK("basic src", be[i], av)
			getacc(1); `CHK("basic dst", 40'h0012000000, av)
			rdw(8'h10); `CHK("basic stat", bs[i], rd)
			wr(8'h10, 32'hfc);
		end
		for (int i = 0; i < 2; i++) begin
			wr(8'h18, 32'h0004_0003);
			wr(8'h04, i ? 32'h51 : 32'h11);
			rdw(8'h18); `CHK("pointer", i ? 32'h0004_0004 : 32'h0004_0000, rd)
		end
		wr(8'h00, 32'h11);
		setacc(0, 40'h003fff8000);
		setacc(1, 40'h0000008000);
		wr(8'h0c, 32'h8000);
		wr(8'h08, 32'hfe00_ff00);
		wr(8'h04, 32'h12);
		getacc(0); `CHK("temp product", 40'h0002000000, av)
		getacc(1); `CHK("filter dst", 40'h0000048000, av)
		rdw(8'h14); `CHK("write-back", 32'h3f00, rd)
		`CHK("memory word", 16'h3f00, mem_word)
		wr(8'h0c, 32'h0);
		wr(8'h08, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, rm[i]);
			setacc(0, ra[i]);
			wr(8'h04, 32'h12);
			rdw(8'h14); `CHK("rounded", re[i], rd)
		end
		wr(8'h00, 32'h500);
		wr(8'h04, 32'h3);
		`CHK("stall", 1'b1, exec_stall)
		`CHK("power mode", 3'h5, power_mode)
		wake <= 1'b1;
		for (int k = 0; k < 20 && exec_stall; k++) @(posedge clk_sys);
		wake <= 1'b0;
		`CHK("woken", 1'b0, exec_stall)
		rdw(8'h10); `CHK("int taken", 1'b1, rd[7])
		for (int i = 0; i < 2; i++) begin
			wr(8'h10, 32'hfc);
			wr(8'h04, i ? 32'h83 : 32'h43);
			`CHK("refused stall", 1'b0, exec_stall)
			rdw(8'h10); `CHK("reject", 1'b1, rd[6])
		end
		wr(8'h10, 32'hfc);
		wr(8'h00, 32'h580);
		wr(8'h04, 32'h3);
		wake <= 1'b1;
		for (int k = 0; k < 20 && exec_stall; k++) @(posedge clk_sys);
		wake <= 1'b0;
		rdw(8'h10); `CHK("masked wake", 32'h0, rd)
		conclude();
	end
endmodule : lsu_datapath_tb
